// ===== char_lcd_instruction_decoder.sv
// Instruction decoder and display state of a character display controller
`timescale 1ns/1ps
`default_nettype none
`include "char_lcd_defs.svh"

// Summary of operation
// - Clear fills display RAM with space code and zeroes address counter.
// - Clear also homes cursor and forces increment direction.
// - Return home zeroes address counter and undoes shift, RAM untouched.
// - Entry mode stores direction: set steps up, clear steps down.
// - Shift flag shifts display only on display RAM writes, not reads or glyph writes.
// - Glyph RAM accesses step the counter like display RAM accesses.
// - Display control holds display, cursor, blink flags; off keeps RAM.
// - Cursor flag shows cursor; blink alternates cursor block and character.
// - Table 0 shift moves cursor by one, or display leaving counter.
// - Shift touches no display data and shifts all lines together.
// - Two-line mode wraps cursor to line two after position forty.
// - Width flag picks 8-bit bus or 4-bit bus of nibble pairs.
// - Line-count flag picks two lines when set, one when clear.
// - With extended set strap low, tall flag without two lines gives 5x16 font, addresses 00H-27H.
// - Table bits pick normal, extension 1 or extension 2 table.
// - Table 2 position flag puts tall rows on commons 1-16 or 9-24.
// - Three-line mode shows the remaining eight commons as normal rows.
// - Busy flag is status bit 7; host waits until it is low.
// - Each RAM read or write steps counter by one per entry mode.
module char_lcd_instruction_decoder #(
  parameter int HOME_CYCLES = `HOME_CYCLES
) (
  input  wire logic       CLOCK,              // 50 MHz clock
  input  wire logic       RESET_N,            // Synchronous reset
  input  wire logic       REG_SELECT_LINE,    // 0 instruction, 1 data
  input  wire logic [7:0] WR_DATA,            // Host write data
  input  wire logic       WR_STROBE,          // Write pulse
  input  wire logic       RD_STROBE,          // Read pulse
  output logic      [7:0] RD_DATA,            // Read data, next cycle
  input  wire logic       EXTENDED_SET_STRAP, // Low enables extension tables
  input  wire logic       THREE_LINE_STRAP,   // High for three-line glass
  input  wire logic [6:0] SCAN_ADDR,          // Display refresh address
  output logic      [7:0] SCAN_DATA,          // Display RAM at refresh address
  output logic      [6:0] CURSOR_ADDR,        // Address counter
  output logic      [6:0] DISPLAY_SHIFT,      // Display shift offset
  output logic            DISPLAY_ON,         // Whole display on
  output logic            CURSOR_ON,          // Cursor shown
  output logic            BLINK_ON,           // Cursor blink
  output logic            TWO_LINE,           // Two-line mode
  output logic            TALL_FONT,          // 5x16 font in use
  output logic            TALL_TOP,           // Tall rows on commons 1-16
  output logic            TALL_BOTTOM,        // Tall rows on commons 9-24
  output logic            BUS_WIDTH_8         // 8-bit host bus
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  char_lcd_pkg::state_type state_r;
  char_lcd_pkg::table_type tbl_r;
  char_lcd_pkg::table_type tbl_eff;
  logic [7:0]  dram_r [`DRAM_DEPTH];
  logic [7:0]  gram_r [`GRAM_DEPTH];
  logic [6:0]  ac_r;
  logic [6:0]  shift_r;
  logic [6:0]  clr_idx_r;
  logic [15:0] cnt_r;
  logic [7:0]  rd_r;
  logic [7:0]  scan_r;
  logic [3:0]  hi_r;
  logic [3:0]  rlo_r;
  logic        nib_r;
  logic        glyph_r;
  logic        id_r;
  logic        s_r;
  logic        disp_r;
  logic        cur_r;
  logic        blink_r;
  logic        bw_r;
  logic        two_r;
  logic        tall_r;
  logic        ud_r;
  logic        busy;
  logic        done;
  logic        cmd;
  logic        dw;
  logic        dr;
  logic        tall_eff;
  logic        narrow;
  logic [7:0]  d;
  logic [7:0]  rd_byte;
  logic [6:0]  len;
  logic        is_clr;
  logic        is_home;
  logic        is_entry;
  logic        is_disp;
  logic        is_shift;
  logic        is_func;
  logic        is_gaddr;
  logic        is_daddr;
  logic        is_ud;

  // Next address counter value for one step
  function automatic logic [6:0] step(input logic [6:0] a, input logic up, input logic gl,
                                      input logic two, input logic nar);
    logic [6:0] r;
    r = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
    if (gl)
    begin
      r = {1'b0, r[5:0]};
    end
    else if (nar)
    begin
      if (up && a == `LINE1_LAST) r = 7'h00;
      else if (!up && a == 7'h00) r = `LINE1_LAST;
    end
    else if (two)
    begin
      if (up && a == `LINE1_LAST) r = `LINE2_FIRST;
      else if (up && a == `LINE2_LAST) r = 7'h00;
      else if (!up && a == `LINE2_FIRST) r = `LINE1_LAST;
      else if (!up && a == 7'h00) r = `LINE2_LAST;
    end
    else
    begin
      if (up && a == `ONE_LINE_LAST) r = 7'h00;
      else if (!up && a == 7'h00) r = `ONE_LINE_LAST;
    end
    return r;
  endfunction

  // ----------------------------------------
  // Host byte assembly
  // ----------------------------------------
  // nibble pair
  assign done = bw_r | nib_r;
  assign d = bw_r ? WR_DATA : {hi_r, WR_DATA[7:4]};
  assign busy = state_r != char_lcd_pkg::ST_IDLE;
  assign cmd = WR_STROBE & done & ~REG_SELECT_LINE & ~busy;
  assign dw = WR_STROBE & done & REG_SELECT_LINE & ~busy;
  assign dr = RD_STROBE & done & REG_SELECT_LINE & ~busy;

  // Nibble phase and held upper nibble
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      nib_r <= 1'b0;
      hi_r <= 4'h0;
    end
    else if (is_func && d[4])
    begin
      nib_r <= 1'b0;
    end
    else if (!bw_r && (WR_STROBE || RD_STROBE))
    begin
      nib_r <= ~nib_r;
      if (WR_STROBE && !nib_r) hi_r <= WR_DATA[7:4];
    end
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  assign tbl_eff = EXTENDED_SET_STRAP ? char_lcd_pkg::TBL_NORMAL : tbl_r;

  always_comb
  begin
    is_clr = 1'b0;
    is_home = 1'b0;
    is_entry = 1'b0;
    is_disp = 1'b0;
    is_shift = 1'b0;
    is_func = 1'b0;
    is_gaddr = 1'b0;
    is_daddr = 1'b0;
    is_ud = 1'b0;
    if (cmd)
    begin
      if (d[7]) is_daddr = 1'b1;
      else if (d[6]) is_gaddr = tbl_eff == char_lcd_pkg::TBL_NORMAL;
      else if (d[5]) is_func = 1'b1;
      else if (d[4])
      begin
        is_shift = tbl_eff == char_lcd_pkg::TBL_NORMAL;
        is_ud = tbl_eff == char_lcd_pkg::TBL_EXT2;
      end
      else if (d[3]) is_disp = 1'b1;
      else if (d[2]) is_entry = 1'b1;
      else if (d[1]) is_home = 1'b1;
      else if (d[0]) is_clr = 1'b1;
    end
  end

  // ----------------------------------------
  // Mode flags
  // ----------------------------------------
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      id_r <= 1'b1;
      s_r <= 1'b0;
      disp_r <= 1'b0;
      cur_r <= 1'b0;
      blink_r <= 1'b0;
      bw_r <= 1'b1;
      two_r <= 1'b0;
      tall_r <= 1'b0;
      tbl_r <= char_lcd_pkg::TBL_NORMAL;
      ud_r <= 1'b1;
    end
    else
    begin
      if (is_clr) id_r <= 1'b1;
      if (is_entry)
      begin
        id_r <= d[1];
        s_r <= d[0];
      end
      if (is_disp)
      begin
        disp_r <= d[2];
        cur_r <= d[1];
        blink_r <= d[0];
      end
      if (is_func)
      begin
        bw_r <= d[4];
        two_r <= d[3];
        tall_r <= d[2];
        tbl_r <= char_lcd_pkg::table_type'(d[1:0]);
      end
      if (is_ud) ud_r <= d[3];
    end
  end

  // ----------------------------------------
  // Address counter and display shift
  // ----------------------------------------
  assign tall_eff = tall_r & ~EXTENDED_SET_STRAP;
  assign narrow = tall_eff & ~two_r;
  assign len = two_r | narrow ? `LEN_TWO_LINE : `LEN_ONE_LINE;

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      ac_r <= 7'h00;
      glyph_r <= 1'b0;
    end
    else if (is_clr || is_home)
    begin
      ac_r <= 7'h00;
      glyph_r <= 1'b0;
    end
    else if (is_daddr)
    begin
      ac_r <= narrow ? {1'b0, d[5:0]} : d[6:0];
      glyph_r <= 1'b0;
    end
    else if (is_gaddr)
    begin
      ac_r <= {1'b0, d[5:0]};
      glyph_r <= 1'b1;
    end
    else if (is_shift && !d[3])
      ac_r <= step(ac_r, d[2], glyph_r, two_r, narrow);
    else if (dw || dr)
      ac_r <= step(ac_r, id_r, glyph_r, two_r, narrow);
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N || is_clr || is_home)
      shift_r <= 7'h00;
    else if ((is_shift && d[3] && !d[2]) || (dw && !glyph_r && s_r && id_r))
      shift_r <= shift_r == 7'(len - 7'h01) ? 7'h00 : 7'(shift_r + 7'h01);
    else if ((is_shift && d[3] && d[2]) || (dw && !glyph_r && s_r && !id_r))
      shift_r <= shift_r == 7'h00 ? 7'(len - 7'h01) : 7'(shift_r - 7'h01);
  end

  // ----------------------------------------
  // Busy sequencing
  // ----------------------------------------
  // busy timing
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      state_r <= char_lcd_pkg::ST_IDLE;
      cnt_r <= 16'h0000;
      clr_idx_r <= 7'h00;
    end
    else
    begin
      case (state_r)
        char_lcd_pkg::ST_IDLE:
        begin
          clr_idx_r <= 7'h00;
          if (is_clr || is_home)
          begin
            cnt_r <= 16'(HOME_CYCLES);
            state_r <= is_clr ? char_lcd_pkg::ST_CLEAR : char_lcd_pkg::ST_EXEC;
          end
          else if (cmd || dw || dr)
          begin
            cnt_r <= 16'(`INSTR_CYCLES);
            state_r <= char_lcd_pkg::ST_EXEC;
          end
        end
        char_lcd_pkg::ST_CLEAR:
        begin
          cnt_r <= 16'(cnt_r - 16'h0001);
          clr_idx_r <= 7'(clr_idx_r + 7'h01);
          if (clr_idx_r == 7'h7F) state_r <= char_lcd_pkg::ST_EXEC;
        end
        char_lcd_pkg::ST_EXEC:
        begin
          cnt_r <= 16'(cnt_r - 16'h0001);
          if (cnt_r <= 16'h0001) state_r <= char_lcd_pkg::ST_IDLE;
        end
        default:
          state_r <= char_lcd_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Display and glyph storage
  // ----------------------------------------
  // fill with space code
  always_ff @(posedge CLOCK)
  begin
    if (state_r == char_lcd_pkg::ST_CLEAR)
      dram_r[clr_idx_r] <= `SPACE_CODE;
    else if (dw && !glyph_r)
      dram_r[ac_r] <= d;
  end

  // Glyph writes
  always_ff @(posedge CLOCK)
  begin
    if (dw && glyph_r)
      gram_r[ac_r[5:0]] <= d;
  end

  // Refresh port
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
      scan_r <= 8'h00;
    else
      scan_r <= dram_r[SCAN_ADDR];
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // busy in bit 7
  always_comb
  begin
    rd_byte = {busy, ac_r};
    if (REG_SELECT_LINE)
      rd_byte = glyph_r ? gram_r[ac_r[5:0]] : dram_r[ac_r];
  end

  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      rd_r <= 8'h00;
      rlo_r <= 4'h0;
    end
    else if (RD_STROBE)
    begin
      if (bw_r)
        rd_r <= rd_byte;
      else if (!nib_r)
      begin
        rd_r <= {rd_byte[7:4], 4'h0};
        rlo_r <= rd_byte[3:0];
      end
      else
        rd_r <= {rlo_r, 4'h0};
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign RD_DATA = rd_r;
  assign SCAN_DATA = scan_r;
  assign CURSOR_ADDR = ac_r;
  assign DISPLAY_SHIFT = shift_r;
  assign DISPLAY_ON = disp_r;
  assign CURSOR_ON = cur_r;
  assign BLINK_ON = blink_r;
  assign TWO_LINE = two_r;
  assign BUS_WIDTH_8 = bw_r;
  assign TALL_FONT = tall_eff & (~two_r | THREE_LINE_STRAP);
  assign TALL_TOP = TALL_FONT & (ud_r | ~THREE_LINE_STRAP);
  assign TALL_BOTTOM = TALL_FONT & ~ud_r & THREE_LINE_STRAP;

endmodule
`default_nettype wire

// ===== char_lcd_defs.svh
// Constants of the character display instruction decoder
`ifndef CHAR_LCD_DEFS_SVH
`define CHAR_LCD_DEFS_SVH
`define CLK_PERIOD_NS 20
`define INSTR_TIME_NS 26300
`define HOME_TIME_NS  1080000
`define INSTR_CYCLES  ((`INSTR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HOME_CYCLES   ((`HOME_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SPACE_CODE    8'h20
`define LINE1_LAST    7'h27
`define LINE2_FIRST   7'h40
`define LINE2_LAST    7'h67
`define ONE_LINE_LAST 7'h4F
`define LEN_TWO_LINE  7'h28
`define LEN_ONE_LINE  7'h50
`define DRAM_DEPTH    128
`define GRAM_DEPTH    64
`define BUSY_BIT      7
`endif

// ===== char_lcd_pkg.sv
// Types of the character display instruction decoder
package char_lcd_pkg;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_CLEAR = 2'b01, ST_EXEC = 2'b11} state_type;
  typedef enum logic [1:0] {TBL_NORMAL = 2'b00, TBL_EXT1 = 2'b01, TBL_EXT2 = 2'b10, TBL_TEST = 2'b11} table_type;
endpackage

// ===== char_lcd_monitor.sv
// Port checker of the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module char_lcd_monitor #(
  parameter int HOME_CYCLES = 54000
) (
  input wire logic       CLOCK,              // Clock
  input wire logic       RESET_N,            // Reset
  input wire logic       REG_SELECT_LINE,    // Select
  input wire logic [7:0] WR_DATA,            // Write data
  input wire logic       WR_STROBE,          // Write
  input wire logic       RD_STROBE,          // Read
  input wire logic [7:0] RD_DATA,            // Read data
  input wire logic       EXTENDED_SET_STRAP, // Strap
  input wire logic       THREE_LINE_STRAP,   // Strap
  input wire logic [6:0] CURSOR_ADDR,        // Counter
  input wire logic [6:0] DISPLAY_SHIFT,      // Shift
  input wire logic       DISPLAY_ON,         // Flag
  input wire logic       CURSOR_ON,          // Flag
  input wire logic       BLINK_ON,           // Flag
  input wire logic       TWO_LINE,           // Flag
  input wire logic       TALL_FONT,          // Flag
  input wire logic       TALL_TOP,           // Flag
  input wire logic       TALL_BOTTOM,        // Flag
  input wire logic       BUS_WIDTH_8         // Flag
);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);
  // Idle poll then clear or home
  sequence idle_home_s;
    RD_STROBE && !REG_SELECT_LINE && BUS_WIDTH_8 ##1 !RD_DATA[7] && !WR_STROBE && !RD_STROBE
      ##1 WR_STROBE && !REG_SELECT_LINE && WR_DATA[7:2] == 6'h00 && WR_DATA[1:0] != 2'b00;
  endsequence
  status_read_a: assert property (
    RD_STROBE && !REG_SELECT_LINE && BUS_WIDTH_8 |=> RD_DATA[6:0] == $past(CURSOR_ADDR))
    else $error("status read wrong");
  read_hold_a: assert property (!RD_STROBE |=> $stable(RD_DATA)) else $error("read data moved");
  ac_cause_a: assert property (
    $changed(CURSOR_ADDR) && $past(RESET_N) |-> $past(WR_STROBE || RD_STROBE)) else $error("counter moved alone");
  shift_cause_a: assert property (
    $changed(DISPLAY_SHIFT) && $past(RESET_N) |-> $past(WR_STROBE)) else $error("shift moved alone");
  flag_cause_a: assert property (
    $changed({DISPLAY_ON, CURSOR_ON, BLINK_ON, TWO_LINE, BUS_WIDTH_8}) && $past(RESET_N)
    |-> $past(WR_STROBE && !REG_SELECT_LINE)) else $error("flag moved alone");
  tall_font_a: assert property (
    TALL_FONT |-> !EXTENDED_SET_STRAP && (!TWO_LINE || THREE_LINE_STRAP)) else $error("tall font wrong");
  tall_place_a: assert property (
    (TALL_TOP || TALL_BOTTOM) == TALL_FONT && !(TALL_TOP && TALL_BOTTOM)
    && (!TALL_BOTTOM || THREE_LINE_STRAP)) else $error("tall rows wrong");
  clear_home_a: assert property (
    idle_home_s |=> CURSOR_ADDR == 7'h00 && DISPLAY_SHIFT == 7'h00) else $error("home not done");
  // Main scenarios
  clear_c: cover property (idle_home_s);
  bottom_c: cover property (TALL_BOTTOM);
  nibble_c: cover property (WR_STROBE && !BUS_WIDTH_8);
endmodule
bind char_lcd_instruction_decoder char_lcd_monitor #(.HOME_CYCLES(HOME_CYCLES)) mon_u (
  .CLOCK(CLOCK), .RESET_N(RESET_N), .REG_SELECT_LINE(REG_SELECT_LINE), .WR_DATA(WR_DATA),
  .WR_STROBE(WR_STROBE), .RD_STROBE(RD_STROBE), .RD_DATA(RD_DATA), .EXTENDED_SET_STRAP(EXTENDED_SET_STRAP),
  .THREE_LINE_STRAP(THREE_LINE_STRAP), .CURSOR_ADDR(CURSOR_ADDR), .DISPLAY_SHIFT(DISPLAY_SHIFT),
  .DISPLAY_ON(DISPLAY_ON), .CURSOR_ON(CURSOR_ON), .BLINK_ON(BLINK_ON), .TWO_LINE(TWO_LINE),
  .TALL_FONT(TALL_FONT), .TALL_TOP(TALL_TOP), .TALL_BOTTOM(TALL_BOTTOM), .BUS_WIDTH_8(BUS_WIDTH_8));
`default_nettype wire

// ===== char_lcd_host.sv
// Host processor model on the instruction port
`timescale 1ns/1ps
`default_nettype none
module char_lcd_host (
  input  wire logic       clock,   // Clock
  input  wire logic [7:0] rd_data, // Read data
  input  wire logic       bus_8,   // Width flag
  output var  logic       reg_sel, // Select
  output var  logic [7:0] wr_data, // Write data
  output var  logic       wr_st,   // Write
  output var  logic       rd_st    // Read
);
  // Idle bus at time zero
  initial
  begin
    reg_sel = 1'b0;
    wr_data = 8'h00;
    wr_st = 1'b0;
    rd_st = 1'b0;
  end
  // One strobe; data inverted once released
  task automatic strobe(input logic w, input logic rs, input logic [7:0] d, output logic [7:0] q);
    @(posedge clock);
    reg_sel <= rs;
    wr_data <= d;
    wr_st <= w;
    rd_st <= !w;
    @(posedge clock);
    wr_st <= 1'b0;
    rd_st <= 1'b0;
    wr_data <= ~d;
    #1 q = rd_data;
  endtask
  task automatic xfer(input logic w, input logic rs, input logic [7:0] d, output logic [7:0] q);
    logic [7:0] a;
    logic [7:0] b;
    if (bus_8)
      strobe(w, rs, d, q);
    else
    begin
      strobe(w, rs, {d[7:4], ~d[3:0]}, a);
      strobe(w, rs, {d[3:0], ~d[3:0]}, b);
      q = {a[7:4], b[7:4]};
    end
  endtask
  task automatic poll();
    logic [7:0] q;
    q = 8'h80;
    for (int i = 0; i < 4000 && q[7] !== 1'b0; i++)
      xfer(1'b0, 1'b0, 8'h00, q);
  endtask
endmodule
`default_nettype wire

// ===== tb_char_lcd_instruction_decoder.sv
// Self-checking bench of the instruction decoder
`timescale 1ns/1ps
`default_nettype none
module tb_char_lcd_instruction_decoder;
  typedef struct packed {logic [7:0] c; logic [6:0] f; logic [6:0] a; logic [6:0] s;} row_type;
  logic       clock, reset_n, extended_set_strap, three, rs, ws, rds;
  logic [7:0] wd, q, rdd, scan_d;
  logic [6:0] scan_a, ac, sh;
  wire  [6:0] f;
  wire        bot;
  int         error_cnt, n_compared;
  row_type    rows [23] = '{'{8'h0F, 7'h71, 7'h00, 7'h00}, '{8'h0A, 7'h21, 7'h00, 7'h00},
    '{8'h38, 7'h29, 7'h00, 7'h00}, '{8'h34, 7'h27, 7'h00, 7'h00}, '{8'h30, 7'h21, 7'h00, 7'h00},
    '{8'hA7, 7'h21, 7'h27, 7'h00}, '{8'h14, 7'h21, 7'h28, 7'h00}, '{8'h10, 7'h21, 7'h27, 7'h00},
    '{8'h18, 7'h21, 7'h27, 7'h01}, '{8'h1C, 7'h21, 7'h27, 7'h00}, '{8'h38, 7'h29, 7'h27, 7'h00},
    '{8'h14, 7'h29, 7'h40, 7'h00}, '{8'h10, 7'h29, 7'h27, 7'h00}, '{8'h18, 7'h29, 7'h27, 7'h01},
    '{8'h02, 7'h29, 7'h00, 7'h00}, '{8'h39, 7'h29, 7'h00, 7'h00}, '{8'h14, 7'h29, 7'h00, 7'h00},
    '{8'h34, 7'h27, 7'h00, 7'h00}, '{8'hE7, 7'h27, 7'h27, 7'h00}, '{8'h14, 7'h27, 7'h00, 7'h00},
    '{8'h38, 7'h29, 7'h00, 7'h00}, '{8'hE7, 7'h29, 7'h67, 7'h00}, '{8'h14, 7'h29, 7'h00, 7'h00}};
  char_lcd_instruction_decoder #(.HOME_CYCLES(200)) dut_u (.CLOCK(clock), .RESET_N(reset_n),
    .REG_SELECT_LINE(rs), .WR_DATA(wd), .WR_STROBE(ws), .RD_STROBE(rds), .RD_DATA(rdd),
    .EXTENDED_SET_STRAP(extended_set_strap), .THREE_LINE_STRAP(three), .SCAN_ADDR(scan_a), .SCAN_DATA(scan_d),
    .CURSOR_ADDR(ac), .DISPLAY_SHIFT(sh), .DISPLAY_ON(f[6]), .CURSOR_ON(f[5]), .BLINK_ON(f[4]),
    .TWO_LINE(f[3]), .TALL_FONT(f[2]), .TALL_TOP(f[1]), .TALL_BOTTOM(bot), .BUS_WIDTH_8(f[0]));
  char_lcd_host host_u (.clock(clock), .rd_data(rdd), .bus_8(f[0]), .reg_sel(rs), .wr_data(wd),
    .wr_st(ws), .rd_st(rds));
  // Verdict and end of run
  task automatic conclude();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Compare one value
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  // Accesses that wait out the busy flag
  task automatic acc(input logic w, input logic r, input logic [7:0] d);
    host_u.poll();
    host_u.xfer(w, r, d, q);
    host_u.poll();
  endtask
  // Clock
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // Hang limit
  initial
  begin
    repeat (95000) @(posedge clock);
    error_cnt++;
    conclude();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    {reset_n, extended_set_strap, three, scan_a} = '0;
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    #1 chk("flags", 8'h01, {1'b0, f});
    chk("rd", 8'h00, rdd);
    foreach (rows[i])
    begin
      acc(1'b1, 1'b0, rows[i].c);
      chk("flags", {1'b0, rows[i].f}, {1'b0, f});
      chk("ac", {1'b0, rows[i].a}, {1'b0, ac});
      chk("shift", {1'b0, rows[i].s}, {1'b0, sh});
    end
    acc(1, 0, 8'h06); acc(1, 0, 8'h80); acc(1, 1, 8'h41); acc(1, 1, 8'h42);
    chk("ac", 8'h02, {1'b0, ac});
    acc(1, 0, 8'h04); acc(1, 1, 8'h43);
    chk("ac", 8'h01, {1'b0, ac});
    acc(1, 0, 8'h07); acc(1, 1, 8'h44);
    chk("shift", 8'h01, {1'b0, sh});
    acc(1, 0, 8'h80); acc(0, 1, 8'h00);
    chk("data", 8'h41, q);
    chk("shift", 8'h01, {1'b0, sh});
    acc(1, 0, 8'h40); acc(1, 1, 8'h1F);
    chk("ac", 8'h01, {1'b0, ac});
    chk("shift", 8'h01, {1'b0, sh});
    acc(1, 0, 8'h04); acc(1, 0, 8'h01);
    chk("ac", 8'h00, {1'b0, ac});
    chk("shift", 8'h00, {1'b0, sh});
    @(posedge clock);
    scan_a <= 7'h45;
    acc(1, 1, 8'h55);
    chk("scan", 8'h20, scan_d);
    chk("ac", 8'h01, {1'b0, ac});
    @(posedge clock);
    three <= 1'b1;
    acc(1, 0, 8'h3E);
    chk("tall", 8'h06, {5'h00, f[2:1], bot});
    acc(1, 0, 8'h10);
    chk("tall", 8'h05, {5'h00, f[2:1], bot});
    chk("ac", 8'h01, {1'b0, ac});
    acc(1, 0, 8'h18);
    chk("tall", 8'h06, {5'h00, f[2:1], bot});
    acc(1, 0, 8'h38);
    chk("tall", 8'h00, {5'h00, f[2:1], bot});
    @(posedge clock);
    three <= 1'b0;
    acc(1, 0, 8'h28); acc(1, 0, 8'h85); acc(0, 0, 8'h00);
    chk("status", 8'h05, q);
    acc(1, 0, 8'h80); acc(0, 1, 8'h00);
    chk("data", 8'h55, q);
    acc(1, 0, 8'h38);
    chk("width", 8'h01, {7'h00, f[0]});
    @(posedge clock);
    extended_set_strap <= 1'b1;
    acc(1, 0, 8'h34);
    chk("tall", 8'h00, {7'h00, f[2]});
    @(posedge clock);
    extended_set_strap <= 1'b0;
    @(posedge clock);
    #1 chk("tall", 8'h01, {7'h00, f[2]});
    @(posedge clock);
    reset_n <= 1'b0;
    @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    #1 chk("flags", 8'h01, {1'b0, f});
    conclude();
  end
endmodule
`default_nettype wire
